// ---- pkg/fmtc_pkg.sv ----
package fmtc_pkg;
	// command codes
	localparam logic [7:0]  CMD_FAULT_CAPTURE_MASK = 8'hd7;
	localparam logic [7:0]  CMD_VOUT_LIMIT_DETECT  = 8'hd8;
	localparam logic [7:0]  CMD_EXT_TEMP_GAIN      = 8'hd9;
	localparam logic [7:0]  CMD_EXT_TEMP_BIAS      = 8'hda;
	// reset values
	localparam logic [15:0] RST_FAULT_CAPTURE_MASK = 16'h0000;
	localparam logic [7:0]  RST_VOUT_LIMIT_DETECT  = 8'h00;
	localparam logic [15:0] RST_EXT_TEMP_GAIN      = 16'hba00;
	localparam logic [15:0] RST_EXT_TEMP_BIAS      = 16'h0000;
	// implemented bits
	localparam logic [15:0] MASK_USED_BITS         = 16'h3cff;
	localparam logic [7:0]  CFG_USED_BITS          = 8'h8f;
	localparam int          CFG_LOW_SIDE_BIT       = 7;
	localparam int          CFG_COUNT_MSB          = 3;
	// linear-11 layout
	localparam int          LIN_EXP_LSB            = 11;
	localparam int          LIN_MANT_MSB           = 10;
	// temperature input fraction bits (1/16 degree)
	localparam int          TEMP_FRAC_BITS         = 4;
	// output pages
	localparam int          PAGE_COUNT             = 2;
	localparam logic [6:0]  DEF_BUS_ADDR           = 7'h40;
	localparam logic [3:0]  BIT_LAST               = 4'h7;

	typedef struct packed {
		logic [15:0] gain;
		logic [15:0] bias;
		logic [7:0]  cfg;
	} fmtc_page_type;

	typedef struct packed {
		logic scl;
		logic sda;
	} fmtc_bus_type;
endpackage

// ---- hdl/fmtc_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// [R1] a set mask bit blocks its fault class from triggering a fault record capture
// [R2] mask bits 13..10: group, other phase, processor, memory crc faults
// [R3] mask bits 7..0: iout uc, iout oc, vin uv, vin ov, ut, ot, vout uv, vout ov
// [R4] fault mask is two bytes, read/write, resets to zero
// [R5] config bit 7 selects low-side device on or off during overvoltage shutdown
// [R6] ov or uv fault declared after N+1 consecutive violations, N in bits 3:0
// [R7] limit config is one read/write byte, reset zero, bits 6:4 unused
// [R8] limit config, gain and bias are held separately per output page
// [R9] gain: linear-11, resets to 1.0, scales external temperature reading
// [R10] bias: linear-11, resets to zero, added to scaled temperature
// [R11] linear-11 is signed 5-bit exponent over signed 11-bit mantissa
// [R12] unused mask and config bits read zero and have no effect
module fmtc_regs
	import fmtc_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = DEF_BUS_ADDR
) (
	// clock and reset
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	// serial bus pins
	input  wire fmtc_bus_type                  bus_in,
	output logic                               sda_out,
	output logic                               sda_oe_n_out,
	// page select
	input  wire logic [PAGE_COUNT-1:0]         page_sel_in,
	// fault classes and capture
	input  wire logic [15:0]                   fault_class_in,
	output logic                               fault_record_capture_out,
	output logic [15:0]                        captured_faults_out,
	// voltage limit detection
	input  wire logic [PAGE_COUNT-1:0]         limit_sample_in,
	input  wire logic [PAGE_COUNT-1:0]         ov_violation_in,
	input  wire logic [PAGE_COUNT-1:0]         uv_violation_in,
	input  wire logic [PAGE_COUNT-1:0]         shutdown_clear_in,
	output logic [PAGE_COUNT-1:0]              ov_fault_out,
	output logic [PAGE_COUNT-1:0]              uv_fault_out,
	output logic [PAGE_COUNT-1:0]              low_side_on_out,
	// external temperature
	input  wire logic signed [15:0]            ext_temp_input_in,
	output logic signed [15:0]                 ext_temp_report_out
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_ADDR = 6'b000010,
		ST_ACK  = 6'b000100,
		ST_WR   = 6'b001000,
		ST_RD   = 6'b010000,
		ST_RACK = 6'b100000
	} fmtc_state_type;

	// linear-11 value applied to a 24-bit signed operand
	function automatic logic signed [39:0] lin_mul(input logic [15:0] lin, input logic signed [23:0] v);
		logic signed [4:0]  e;
		logic signed [39:0] p;
		e = lin[15:LIN_EXP_LSB];
		p = 40'(v * $signed(lin[LIN_MANT_MSB:0])); // [R11]
		lin_mul = (e < 0) ? (p >>> (-e)) : (p <<< e);
	endfunction

	fmtc_bus_type                bus_s1_q, bus_s2_q, bus_s3_q;
	fmtc_state_type              state_q;
	logic [7:0]                  shift_q, cmd_q;
	logic [3:0]                  bit_q;
	logic                        drive_q, rd_q, nack_q, rdx_q;
	logic [1:0]                  idx_q;
	logic [15:0]                 wbuf_q, mask_q, rd_val, masked;
	fmtc_page_type               page_q [PAGE_COUNT];
	logic [3:0]                  ov_cnt_q [PAGE_COUNT], uv_cnt_q [PAGE_COUNT];
	logic                        scl_rise, scl_fall, start_c, stop_c, commit;
	int                          sel;

	// pin synchronisers
	always_ff @(posedge clk_in) begin
		bus_s1_q <= bus_in;
		bus_s2_q <= bus_s1_q;
		bus_s3_q <= bus_s2_q;
	end

	assign scl_rise     = bus_s2_q.scl & ~bus_s3_q.scl;
	assign scl_fall     = ~bus_s2_q.scl & bus_s3_q.scl;
	assign start_c      = bus_s2_q.scl & bus_s3_q.scl & bus_s3_q.sda & ~bus_s2_q.sda;
	assign stop_c       = bus_s2_q.scl & bus_s3_q.scl & ~bus_s3_q.sda & bus_s2_q.sda;
	assign sda_out      = 1'b0;
	assign sda_oe_n_out = ~drive_q;

	// selected page index
	always_comb begin
		sel = 0;
		for (int i = 0; i < PAGE_COUNT; i++) begin
			if (page_sel_in[i]) sel = i;
		end
	end

	// read decode
	always_comb begin
		unique case (cmd_q)
			CMD_FAULT_CAPTURE_MASK: rd_val = mask_q & MASK_USED_BITS; // [R12]
			CMD_VOUT_LIMIT_DETECT:  rd_val = {8'h00, page_q[sel].cfg & CFG_USED_BITS};
			CMD_EXT_TEMP_GAIN:      rd_val = page_q[sel].gain;
			CMD_EXT_TEMP_BIAS:      rd_val = page_q[sel].bias;
			default:                rd_val = 16'hffff;
		endcase
	end

	// write lands at stop once the full length has arrived
	assign commit = stop_c & (state_q != ST_IDLE) & ~rd_q &
		((idx_q == 2'h2 && cmd_q == CMD_VOUT_LIMIT_DETECT) || (idx_q == 2'h3 && cmd_q != CMD_VOUT_LIMIT_DETECT));

	// serial byte engine
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			bit_q   <= 4'h0;
			drive_q <= 1'b0;
			rd_q    <= 1'b0;
			nack_q  <= 1'b0;
			idx_q   <= 2'h0;
			cmd_q   <= 8'h00;
			wbuf_q  <= 16'h0000;
			rdx_q   <= 1'b0;
		end else if (start_c) begin
			state_q <= ST_ADDR;
			bit_q   <= 4'h0;
			drive_q <= 1'b0;
			rd_q    <= 1'b0;
			rdx_q   <= 1'b0;
		end else if (stop_c) begin
			state_q <= ST_IDLE;
			drive_q <= 1'b0;
			idx_q   <= 2'h0;
		end else begin
			unique case (state_q)
				ST_IDLE: ;
				ST_ADDR, ST_WR: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], bus_s2_q.sda};
						bit_q   <= bit_q + 4'h1;
						if (bit_q == BIT_LAST) begin
							if (state_q == ST_ADDR) begin
								state_q <= (shift_q[6:0] == BUS_ADDR) ? ST_ACK : ST_IDLE;
								rd_q    <= bus_s2_q.sda;
								if (!bus_s2_q.sda) idx_q <= 2'h0;
							end else begin
								state_q <= ST_ACK;
								if (idx_q == 2'h0) cmd_q <= {shift_q[6:0], bus_s2_q.sda};
								else if (idx_q == 2'h1) wbuf_q[7:0] <= {shift_q[6:0], bus_s2_q.sda};
								else wbuf_q[15:8] <= {shift_q[6:0], bus_s2_q.sda};
								if (idx_q != 2'h3) idx_q <= idx_q + 2'h1;
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (!drive_q) begin
							drive_q <= 1'b1;
						end else if (rd_q) begin
							state_q <= ST_RD;
							shift_q <= rd_val[7:0];
							drive_q <= ~rd_val[7];
							bit_q   <= 4'h0;
						end else begin
							state_q <= ST_WR;
							drive_q <= 1'b0;
							bit_q   <= 4'h0;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						bit_q <= bit_q + 4'h1;
						if (bit_q == BIT_LAST) begin
							drive_q <= 1'b0;
							state_q <= ST_RACK;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							drive_q <= ~shift_q[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						nack_q <= bus_s2_q.sda;
					end else if (scl_fall) begin
						if (nack_q) begin
							state_q <= ST_IDLE;
						end else begin
							rdx_q   <= 1'b1;
							state_q <= ST_RD;
							shift_q <= rd_val[15:8];
							drive_q <= ~rd_val[15];
							bit_q   <= 4'h0;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// global fault mask
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mask_q <= RST_FAULT_CAPTURE_MASK; // [R4]
		end else if (commit && cmd_q == CMD_FAULT_CAPTURE_MASK) begin
			mask_q <= wbuf_q & MASK_USED_BITS; // [R12]
		end
	end

	// per page registers and limit debounce
	generate
		for (genvar p = 0; p < PAGE_COUNT; p++) begin : g_page
			logic wr_here;
			assign wr_here = commit & (sel == p);

			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					page_q[p].gain <= RST_EXT_TEMP_GAIN; // [R9]
					page_q[p].bias <= RST_EXT_TEMP_BIAS; // [R10]
					page_q[p].cfg  <= RST_VOUT_LIMIT_DETECT; // [R7]
				end else if (wr_here) begin // [R8]
					if (cmd_q == CMD_EXT_TEMP_GAIN) page_q[p].gain <= wbuf_q;
					if (cmd_q == CMD_EXT_TEMP_BIAS) page_q[p].bias <= wbuf_q;
					if (cmd_q == CMD_VOUT_LIMIT_DETECT) page_q[p].cfg <= wbuf_q[7:0] & CFG_USED_BITS; // [R7] [R12]
				end
			end

			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					ov_cnt_q[p]     <= 4'h0;
					uv_cnt_q[p]     <= 4'h0;
					ov_fault_out[p] <= 1'b0;
					uv_fault_out[p] <= 1'b0;
				end else begin
					ov_fault_out[p] <= 1'b0;
					uv_fault_out[p] <= 1'b0;
					if (limit_sample_in[p]) begin
						ov_cnt_q[p] <= 4'h0;
						uv_cnt_q[p] <= 4'h0;
						if (ov_violation_in[p]) begin
							if (ov_cnt_q[p] == page_q[p].cfg[CFG_COUNT_MSB:0]) begin
								ov_fault_out[p] <= 1'b1; // [R6]
								ov_cnt_q[p]     <= 4'h0;
							end else begin
								ov_cnt_q[p] <= ov_cnt_q[p] + 4'h1;
							end
						end
						if (uv_violation_in[p]) begin
							if (uv_cnt_q[p] == page_q[p].cfg[CFG_COUNT_MSB:0]) begin
								uv_fault_out[p] <= 1'b1; // [R6]
								uv_cnt_q[p]     <= 4'h0;
							end else begin
								uv_cnt_q[p] <= uv_cnt_q[p] + 4'h1;
							end
						end
					end
				end
			end

			// ov shutdown low-side drive state
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					low_side_on_out[p] <= 1'b0;
				end else if (ov_fault_out[p]) begin
					low_side_on_out[p] <= page_q[p].cfg[CFG_LOW_SIDE_BIT]; // [R5]
				end else if (shutdown_clear_in[p]) begin
					low_side_on_out[p] <= 1'b0;
				end
			end
		end
	endgenerate

	// fault record capture gating
	assign masked = fault_class_in & ~mask_q; // [R1] [R2] [R3]
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fault_record_capture_out <= 1'b0;
			captured_faults_out      <= 16'h0000;
		end else begin
			fault_record_capture_out <= |masked; // [R1]
			if (|masked) begin
				captured_faults_out <= masked;
			end
		end
	end

	// calibrated external temperature
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ext_temp_report_out <= 16'sh0000;
		end else begin
			ext_temp_report_out <= 16'(lin_mul(page_q[sel].gain, 24'(ext_temp_input_in))
				+ lin_mul(page_q[sel].bias, 24'sh000010)); // [R9] [R10] [R11]
		end
	end

	a_capture_blocked: assert property (@(posedge clk_in) disable iff (rst_in) // [R1]
		((fault_class_in & ~mask_q) == 16'h0000) |=> !fault_record_capture_out)
		else $error("masked fault triggered capture");
	a_capture_fires: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
		(fault_class_in[13] && !mask_q[13]) |=> fault_record_capture_out && captured_faults_out[13])
		else $error("unmasked group fault not captured");
	a_low_mask_map: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
		(fault_class_in[0] && mask_q[0] && fault_class_in[15:1] == 15'h0000) |=> !fault_record_capture_out)
		else $error("vout ov mask bit ignored");
	a_mask_reset: assert property (@(posedge clk_in) rst_in |=> mask_q == RST_FAULT_CAPTURE_MASK) // [R4]
		else $error("mask reset value wrong");
	a_low_side_state: assert property (@(posedge clk_in) disable iff (rst_in) // [R5]
		ov_fault_out[0] |=> low_side_on_out[0] == $past(page_q[0].cfg[CFG_LOW_SIDE_BIT]))
		else $error("low side state wrong after ov");
	a_debounce_zero: assert property (@(posedge clk_in) disable iff (rst_in) // [R6]
		(limit_sample_in[0] && ov_violation_in[0] && page_q[0].cfg[CFG_COUNT_MSB:0] == 4'h0) |=> ov_fault_out[0])
		else $error("single violation did not fault at n zero");
	a_debounce_early: assert property (@(posedge clk_in) disable iff (rst_in) // [R6]
		(limit_sample_in[0] && ov_cnt_q[0] < page_q[0].cfg[CFG_COUNT_MSB:0]) |=> !ov_fault_out[0])
		else $error("ov fault declared early");
	a_cfg_unused: assert property (@(posedge clk_in) disable iff (rst_in) // [R7]
		(page_q[0].cfg & ~CFG_USED_BITS) == 8'h00 && (mask_q & ~MASK_USED_BITS) == 16'h0000) else $error("unused bit set");
	a_page_isolate: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
		(commit && sel == 0) |=> $stable(page_q[1])) else $error("write disturbed other page");
	a_gain_reset: assert property (@(posedge clk_in) rst_in |=> // [R9]
		page_q[0].gain == RST_EXT_TEMP_GAIN && page_q[1].bias == RST_EXT_TEMP_BIAS) else $error("calibration reset wrong");
	a_unity_temp: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
		(page_q[sel].gain == RST_EXT_TEMP_GAIN && page_q[sel].bias == RST_EXT_TEMP_BIAS)
		##1 $stable(ext_temp_input_in) && $stable(page_q[sel]) |-> ext_temp_report_out == ext_temp_input_in)
		else $error("unity calibration not transparent");
	a_read_unused: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
		cmd_q == CMD_FAULT_CAPTURE_MASK |-> rd_val[15:14] == 2'b00 && rd_val[9:8] == 2'b00)
		else $error("unused mask bits read back set");
	c_capture: cover property (@(posedge clk_in) fault_record_capture_out);
	c_ov_fault: cover property (@(posedge clk_in) ov_fault_out[0] && page_q[0].cfg[CFG_COUNT_MSB:0] != 4'h0);
	c_commit: cover property (@(posedge clk_in) commit);
	c_read: cover property (@(posedge clk_in) state_q == ST_RD && rdx_q);
endmodule

// ---- verif/fmtc_host.sv ----
`timescale 1ns/1ps
module fmtc_host
	import fmtc_pkg::*;
#(
	parameter logic [6:0] ADDR = DEF_BUS_ADDR
) (
	// clock
	input  wire logic clk_in,
	// bus levels, 1 = released
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// clock stands high between frames
	task automatic start();
		tk(4);
		sda_out = 1'b1;
		tk(4);
		scl_out = 1'b1;
		tk(8);
		sda_out = 1'b0;
		tk(8);
		scl_out = 1'b0;
	endtask
	task automatic stop();
		tk(4);
		sda_out = 1'b0;
		tk(4);
		scl_out = 1'b1;
		tk(8);
		sda_out = 1'b1;
		tk(8);
	endtask
	// eight bits msb first, then the acknowledge slot
	task automatic byte_io(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			tk(4);
			sda_out = d[i];
			tk(4);
			scl_out = 1'b1;
			tk(4);
			q[i] = sda_in;
			tk(4);
			scl_out = 1'b0;
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] v, input int n, output logic nak);
		logic [8:0] q0, q1, q2, q3;
		start();
		byte_io({a, 2'b01}, q0);
		byte_io({c, 1'b1}, q1);
		byte_io({v[7:0], 1'b1}, q2);
		q3 = '0;
		if (n == 2) byte_io({v[15:8], 1'b1}, q3);
		stop();
		nak = q0[0] | q1[0] | q2[0] | q3[0];
	endtask
	task automatic rd(input logic [7:0] c, input int n, output logic [15:0] v);
		logic [8:0] q0, q1;
		start();
		byte_io({ADDR, 2'b01}, q0);
		byte_io({c, 1'b1}, q0);
		start();
		byte_io({ADDR, 2'b11}, q0);
		byte_io({8'hff, n == 1}, q0);
		q1 = '0;
		if (n == 2) byte_io(9'h1ff, q1);
		stop();
		v = {q1[8:1], q0[8:1]};
	endtask
endmodule

// ---- verif/fmtc_regs_tb_top.sv ----
`timescale 1ns/1ps
module fmtc_regs_tb_top
	import fmtc_pkg::*;
;
	logic                  clk_in, rst_in, h_scl, h_sda, d_sda, d_oe_n, cap, nak;
	fmtc_bus_type          bus;
	logic [PAGE_COUNT-1:0] page_sel_in, smp, ovv, uvv, clr, ovf, uvf, lso;
	logic [15:0]           fault_class_in, capf, v, m, f;
	logic signed [15:0]    t_in, t_rep;
	logic [7:0]            c;
	int                    errors, n_compared, cc, fc, p, c0, n, s, u;
	logic [15:0]           rv [4] = '{RST_FAULT_CAPTURE_MASK, 16'(RST_VOUT_LIMIT_DETECT),
		RST_EXT_TEMP_GAIN, RST_EXT_TEMP_BIAS};
	logic [15:0]           um [4] = '{16'h3cff, 16'h008f, 16'hffff, 16'hffff};
	logic [15:0]           tg [3] = '{16'hba00, 16'h0002, 16'hf805};
	logic [15:0]           tb [3] = '{16'h0000, 16'h0005, 16'hfffd};

	assign bus = {h_scl, h_sda & (d_oe_n | d_sda)};

	fmtc_regs dut (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus), .sda_out(d_sda), .sda_oe_n_out(d_oe_n),
		.page_sel_in(page_sel_in), .fault_class_in(fault_class_in), .fault_record_capture_out(cap),
		.captured_faults_out(capf), .limit_sample_in(smp), .ov_violation_in(ovv), .uv_violation_in(uvv),
		.shutdown_clear_in(clr), .ov_fault_out(ovf), .uv_fault_out(uvf), .low_side_on_out(lso),
		.ext_temp_input_in(t_in), .ext_temp_report_out(t_rep));
	fmtc_host host (.clk_in(clk_in), .sda_in(bus.sda), .scl_out(h_scl), .sda_out(h_sda));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (!rst_in) begin
			cc <= cc + cap;
			fc <= fc + ovf[p] + uvf[p];
		end
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic put(input int pg, input logic [7:0] cm, input logic [15:0] d);
		page_sel_in = 2'(1 << pg);
		host.wr(DEF_BUS_ADDR, cm, d, cm == CMD_VOUT_LIMIT_DETECT ? 1 : 2, nak);
	endtask
	task automatic get(input int pg, input logic [7:0] cm, output logic [15:0] d);
		page_sel_in = 2'(1 << pg);
		host.rd(cm, cm == CMD_VOUT_LIMIT_DETECT ? 1 : 2, d);
	endtask
	// linear-11: exponent over mantissa, bias in whole degrees, scaled by 16 to 1/16 degree
	function automatic logic [15:0] exp_rep(input logic [15:0] g, input logic [15:0] b, input logic signed [15:0] t);
		int gn, bn, r, e;
		gn = $signed(g[15:11]);
		bn = $signed(b[15:11]);
		r = t * $signed(g[10:0]);
		e = 16 * $signed(b[10:0]);
		r = gn < 0 ? r >>> -gn : r <<< gn;
		e = bn < 0 ? e >>> -bn : e <<< bn;
		return 16'(r + e);
	endfunction

	initial begin
		repeat (100000) @(posedge clk_in);
		errors++;
		$display("BAD watchdog expected finish seen hang");
		end_of_test();
	end

	initial begin
		rst_in = 1'b1;
		page_sel_in = 2'b01;
		fault_class_in = '0;
		{smp, ovv, uvv, clr} = '0;
		t_in = '0;
		{errors, n_compared, cc, fc, p} = '0;
		void'($urandom(21433));
		repeat (4) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clk_in);
		for (int k = 0; k < 4; k++) begin
			c = CMD_FAULT_CAPTURE_MASK + 8'(k);
			get(0, c, v);
			chk("reset", v, rv[k]);
			m = 16'($urandom);
			put(0, c, m);
			put(1, c, ~m);
			get(0, c, v);
			chk("page0", v, (k == 0 ? ~m : m) & um[k]);
			get(1, c, v);
			chk("page1", v, ~m & um[k]);
		end
		put(0, CMD_FAULT_CAPTURE_MASK, 16'hffff);
		host.wr(DEF_BUS_ADDR ^ 7'h01, CMD_FAULT_CAPTURE_MASK, 16'h0000, 2, nak);
		chk("nak", 16'(nak), 16'h0001);
		get(0, CMD_FAULT_CAPTURE_MASK, v);
		chk("unused", v, 16'h3cff);
		$display("register test done");
		for (int r = 0; r < 4; r++) begin
			m = r == 0 ? 16'h0000 : r == 1 ? 16'hffff : 16'($urandom);
			put(0, CMD_FAULT_CAPTURE_MASK, m);
			for (int b = 0; b < 17; b++) begin
				if (b == 16 || um[0][b]) begin
					f = b == 16 ? 16'($urandom) & 16'h3cff : 16'h0001 << b;
					c0 = cc;
					fault_class_in = f;
					@(negedge clk_in);
					fault_class_in = '0;
					repeat (3) @(negedge clk_in);
					chk("capture", 16'(cc - c0), 16'((f & ~m) != 0));
					if ((f & ~m) != 0) chk("faults", capf, f & ~m);
				end
			end
		end
		$display("capture test done");
		for (int q = 0; q < 4; q++) begin
			p = q % 2;
			u = q / 2;
			n = q == 0 ? 0 : q == 1 ? 15 : $urandom % 16;
			s = $urandom % 2;
			put(p, CMD_VOUT_LIMIT_DETECT, 16'(s * 128 + n));
			c0 = fc;
			for (int i = 0; i <= 2 * n + 1; i++) begin
				smp[p] = 1'b1;
				ovv[p] = u == 0 && i != n;
				uvv[p] = u == 1 && i != n;
				@(negedge clk_in);
				smp[p] = 1'b0;
				repeat (3) @(negedge clk_in);
				chk("declare", 16'(fc - c0), 16'(i == 2 * n + 1));
			end
			chk("low side", 16'(lso[p]), 16'(u == 0 && s == 1));
			{ovv, uvv} = '0;
			clr[p] = 1'b1;
			@(negedge clk_in);
			clr[p] = 1'b0;
			chk("cleared", 16'(lso[p]), 16'h0000);
		end
		$display("limit test done");
		for (int j = 0; j < 3; j++) begin
			put(0, CMD_EXT_TEMP_GAIN, tg[j]);
			put(0, CMD_EXT_TEMP_BIAS, tb[j]);
			for (int i = 0; i < 4; i++) begin
				t_in = 16'(($urandom % 1601) * 2 - 1600);
				repeat (4) @(negedge clk_in);
				chk("report", t_rep, exp_rep(tg[j], tb[j], t_in));
			end
		end
		$display("temperature test done");
		end_of_test();
	end
endmodule
